// ===== inc/psm_pkg.sv
// Constants, register layout and state types for the power-state manager.
// Assumes one 25 MHz clock shared by both ends and the link between them.
// Notes on behaviour
// - One normal state, two sleeps, registers kept.
// - Host only reads control in sleep.
// - Ready cleared in sleep until fully awake.
// - Writes ignored until first read after reset.
// - Test-register write wakes, resets state select.
// - Select 01 enters wake-on-LAN sleep.
// - LAN detection auto-on; pin needs both enables.
// - LAN wake detection sets status to 10.
// - Interrupt flag set regardless of pin enable.
// - Energy sleep: PHY bit first, then 10.
// - Carrier in energy sleep sets status 01.
// - Host clears PHY energy bit after ready.
// - Power blocks gated per sleep state.
// - Flag held while event; write one clears.
// - Pulse select: 50ms pulse, else static.
// - Pin drops on status, enable, pin-enable clear.
// - Wake status readable while asleep.
// - PHY power-down bit; clearing resets PHY.
// - PHY energy-detect mode bit controls mode.
// - Ready set within 2ms of wake write.
package psm_pkg;
   // Device register offsets on the link
   localparam logic [7:0] PSM_A_CTRL = 8'h00;
   localparam logic [7:0] PSM_A_TEST = 8'h04;
   localparam logic [7:0] PSM_A_IRQ = 8'h08;
   localparam logic [7:0] PSM_A_PHY0 = 8'h0C;
   localparam logic [7:0] PSM_A_PHY17 = 8'h10;
   // Control, interrupt and PHY register fields
   localparam int PSM_B_READY = 0;
   localparam int PSM_B_PME_EN = 1;
   localparam int PSM_B_PULSE = 3;
   localparam int PSM_B_WAKE_STATUS_FIELD = 4;
   localparam int PSM_B_ENERGY_WAKE_ENABLE = 8;
   localparam int PSM_B_WAKE_LAN_ENABLE = 9;
   localparam int PSM_B_MODE = 12;
   localparam int PSM_B_IRQ_PME = 0;
   localparam int PSM_B_PHY_PD = 11;
   localparam int PSM_B_PHY_ED = 13;
   localparam logic [1:0] PSM_MODE_FULL = 2'h0;
   localparam logic [1:0] PSM_MODE_WOL = 2'h1;
   localparam logic [1:0] PSM_MODE_ED = 2'h2;
   localparam logic [1:0] PSM_WAKE_STATUS_FIELD_WOL = 2'h2;
   localparam logic [1:0] PSM_WAKE_STATUS_FIELD_ED = 2'h1;
   localparam logic [31:0] PSM_TEST_VAL = 32'h87654321;
   // Timing
   localparam int unsigned PSM_CLK_KHZ = 25000;
   localparam int unsigned PSM_WAKE_US = 2000;
   localparam int unsigned PSM_PULSE_MS = 50;
   localparam int unsigned PSM_WAKE_CYC = PSM_WAKE_US * PSM_CLK_KHZ / 1000;
   localparam int unsigned PSM_PULSE_CYC = PSM_PULSE_MS * PSM_CLK_KHZ;
   localparam int PSM_CW = 21;
   // Host-side APB register offsets and fields
   localparam logic [7:0] PSM_H_CMD = 8'h00;
   localparam logic [7:0] PSM_H_WDATA = 8'h04;
   localparam logic [7:0] PSM_H_RDATA = 8'h08;
   localparam logic [7:0] PSM_H_STAT = 8'h0C;
   localparam int PSM_HB_GO = 0;
   localparam int PSM_HB_WR = 1;
   localparam int PSM_HB_ADDR = 8;
   localparam int PSM_HB_BUSY = 0;
   localparam int PSM_HB_PME = 1;
   typedef enum logic [1:0] {PSM_FULL, PSM_WOL, PSM_ENERGY, PSM_WAKING} psm_state_t;
   typedef enum logic {PSM_H_IDLE, PSM_H_BUSY} psm_hstate_t;
endpackage

// ===== inc/psm_if.sv
// Link between host controller and power-state manager device.
// Request is a level held by the host until ack; pme is the event pin.
`timescale 1ns/1ps
interface psm_if;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic ack;
   logic pme;
   modport dev (input req, input we, input addr, input wdata, output rdata, output ack,
      output pme);
   modport host (output req, output we, output addr, output wdata, input rdata, input ack,
      input pme);
endinterface

// ===== rtl/psm_device.sv
// Power-state manager: sleep states, wake, event pin and interrupt flag.
// Assumes the host holds req until ack and wake inputs come from pins.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module psm_device
   import psm_pkg::*;
#(
   parameter int unsigned WAKE_CYC = PSM_WAKE_CYC,
   parameter int unsigned PULSE_CYC = PSM_PULSE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   psm_if.dev bus,
   input wire logic wake_frame,
   input wire logic magic_pkt,
   input wire logic carrier,
   output logic ready,
   output logic irq_status,
   output logic mac_clk_en,
   output logic int_clk_en,
   output logic rx_pm_en,
   output logic mac_pm_en,
   output logic phy_pwr_down,
   output logic phy_ed_mode,
   output logic phy_reset
);
   typedef struct packed {
      psm_state_t st;
      logic ready;
      logic armed;
      logic [1:0] mode;
      logic pme_en;
      logic pulse_sel;
      logic wake_lan_enable;
      logic energy_wake_enable;
      logic [1:0] wake_status_field;
      logic irq;
      logic phy_pd;
      logic phy_ed;
      logic phy_rst;
      logic [PSM_CW-1:0] wcnt;
      logic [PSM_CW-1:0] pcnt;
      logic pulse_on;
      logic pint_d;
      logic [1:0] wf_s;
      logic [1:0] mp_s;
      logic [1:0] cr_s;
      logic ack;
      logic [31:0] rdata;
      logic pme;
      logic mac_en;
      logic int_en;
      logic rxpm_en;
      logic macpm_en;
   } psm_dev_t;

   psm_dev_t s_r;
   psm_dev_t s_nxt;
   logic [31:0] ctrl_word;
   logic take;
   logic sleep;
   logic pint;

   // Control word as the host sees it
   always_comb begin
      ctrl_word = 32'h00000000;
      ctrl_word[PSM_B_READY] = s_r.ready;
      ctrl_word[PSM_B_PME_EN] = s_r.pme_en;
      ctrl_word[PSM_B_PULSE] = s_r.pulse_sel;
      ctrl_word[PSM_B_WAKE_STATUS_FIELD +: 2] = s_r.wake_status_field;
      ctrl_word[PSM_B_ENERGY_WAKE_ENABLE] = s_r.energy_wake_enable;
      ctrl_word[PSM_B_WAKE_LAN_ENABLE] = s_r.wake_lan_enable;
      ctrl_word[PSM_B_MODE +: 2] = s_r.mode;
   end

   // Next-state logic for the whole block
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.phy_rst = 1'b0;
      // Pins cross into this clock through two stages
      s_nxt.wf_s = {s_r.wf_s[0], wake_frame};
      s_nxt.mp_s = {s_r.mp_s[0], magic_pkt};
      s_nxt.cr_s = {s_r.cr_s[0], carrier};
      sleep = (s_r.st == PSM_WOL) || (s_r.st == PSM_ENERGY);
      // strobe only
      // The request level is decoded directly, no gated clock is involved
      take = bus.req && !s_r.ack;
      if (take && !bus.we) begin
         s_nxt.ack = 1'b1;
         s_nxt.armed = 1'b1;
         if (sleep || !s_r.ready) begin
            s_nxt.rdata = (bus.addr == PSM_A_CTRL) ? ctrl_word : 32'h00000000;
         end else begin
            unique case (bus.addr)
               PSM_A_CTRL: s_nxt.rdata = ctrl_word;
               PSM_A_TEST: s_nxt.rdata = PSM_TEST_VAL;
               PSM_A_IRQ: s_nxt.rdata = {31'h00000000, s_r.irq};
               PSM_A_PHY0: s_nxt.rdata = 32'(s_r.phy_pd) << PSM_B_PHY_PD;
               PSM_A_PHY17: s_nxt.rdata = 32'(s_r.phy_ed) << PSM_B_PHY_ED;
               default: s_nxt.rdata = 32'h00000000;
            endcase
         end
      end else if (take) begin
         s_nxt.ack = 1'b1;
         if (sleep && bus.addr == PSM_A_TEST) begin
            s_nxt.st = PSM_WAKING;
            s_nxt.mode = PSM_MODE_FULL;
            s_nxt.wcnt = '0;
            s_nxt.armed = 1'b0;
         end else if (s_r.ready && s_r.armed && s_r.st == PSM_FULL) begin
            unique case (bus.addr)
               PSM_A_CTRL: begin
                  s_nxt.pme_en = bus.wdata[PSM_B_PME_EN];
                  s_nxt.pulse_sel = bus.wdata[PSM_B_PULSE];
                  s_nxt.energy_wake_enable = bus.wdata[PSM_B_ENERGY_WAKE_ENABLE];
                  s_nxt.wake_lan_enable = bus.wdata[PSM_B_WAKE_LAN_ENABLE];
                  // Wake status is write-one-to-clear
                  s_nxt.wake_status_field = s_r.wake_status_field & ~bus.wdata[PSM_B_WAKE_STATUS_FIELD +: 2];
                  if (bus.wdata[PSM_B_MODE +: 2] == PSM_MODE_WOL) begin
                     s_nxt.st = PSM_WOL;
                     s_nxt.mode = PSM_MODE_WOL;
                     s_nxt.ready = 1'b0;
                  end else if (bus.wdata[PSM_B_MODE +: 2] == PSM_MODE_ED) begin
                     s_nxt.st = PSM_ENERGY;
                     s_nxt.mode = PSM_MODE_ED;
                     s_nxt.ready = 1'b0;
                  end
               end
               PSM_A_IRQ: if (bus.wdata[PSM_B_IRQ_PME]) s_nxt.irq = 1'b0;
               PSM_A_PHY0: begin
                  s_nxt.phy_pd = bus.wdata[PSM_B_PHY_PD];
                  s_nxt.phy_rst = s_r.phy_pd && !bus.wdata[PSM_B_PHY_PD];
               end
               PSM_A_PHY17: s_nxt.phy_ed = bus.wdata[PSM_B_PHY_ED];
               default: ;
            endcase
         end
         // other writes dropped
         // Writes in sleep other than to the test register, or before ready, are acked but have no effect
      end
      if (s_r.st == PSM_WAKING) begin
         s_nxt.wcnt = s_r.wcnt + 1'b1;
         if (s_r.wcnt >= PSM_CW'(WAKE_CYC - 1)) begin
            s_nxt.st = PSM_FULL;
            s_nxt.ready = 1'b1;
         end
      end
      // LAN and energy wake status
      // Detection is applied after the clear so a same-cycle event wins
      if (s_r.st == PSM_WOL && (s_r.wf_s[1] || s_r.mp_s[1])) begin
         s_nxt.wake_status_field = PSM_WAKE_STATUS_FIELD_WOL;
      end
      if (s_r.st == PSM_ENERGY && s_r.cr_s[1]) begin
         s_nxt.wake_status_field = PSM_WAKE_STATUS_FIELD_ED;
      end
      pint = (s_nxt.wake_status_field[1] && s_nxt.wake_lan_enable) || (s_nxt.wake_status_field[0] && s_nxt.energy_wake_enable);
      if (pint) begin
         s_nxt.irq = 1'b1;
      end
      s_nxt.pint_d = pint;
      if (!pint || !s_nxt.pme_en) begin
         s_nxt.pulse_on = 1'b0;
         s_nxt.pcnt = '0;
      end else if (!s_r.pint_d) begin
         s_nxt.pulse_on = 1'b1;
         s_nxt.pcnt = '0;
      end else if (s_r.pulse_on) begin
         s_nxt.pcnt = s_r.pcnt + 1'b1;
         if (s_r.pcnt >= PSM_CW'(PULSE_CYC - 1)) begin
            s_nxt.pulse_on = 1'b0;
         end
      end
      s_nxt.pme = pint && s_nxt.pme_en && (s_nxt.pulse_sel ? s_nxt.pulse_on : 1'b1);
      s_nxt.mac_en = (s_nxt.st == PSM_FULL) || (s_nxt.st == PSM_WAKING);
      s_nxt.macpm_en = s_nxt.mac_en;
      s_nxt.int_en = s_nxt.st != PSM_ENERGY;
      s_nxt.rxpm_en = s_nxt.st != PSM_ENERGY;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.st <= PSM_FULL;
         s_r.ready <= 1'b1;
         s_r.mac_en <= 1'b1;
         s_r.macpm_en <= 1'b1;
         s_r.int_en <= 1'b1;
         s_r.rxpm_en <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.ack = s_r.ack;
   assign bus.rdata = s_r.rdata;
   assign bus.pme = s_r.pme;
   assign ready = s_r.ready;
   assign irq_status = s_r.irq;
   assign mac_clk_en = s_r.mac_en;
   assign int_clk_en = s_r.int_en;
   assign rx_pm_en = s_r.rxpm_en;
   assign mac_pm_en = s_r.macpm_en;
   assign phy_pwr_down = s_r.phy_pd;
   assign phy_ed_mode = s_r.phy_ed;
   assign phy_reset = s_r.phy_rst;
endmodule

// ===== rtl/psm_host.sv
// Host controller: APB slave registers that issue link transfers.
// Assumes the device acks every request it sees; pme arrives as a pin.
`timescale 1ns/1ps
module psm_host
   import psm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   psm_if.host bus
);
   typedef struct packed {
      psm_hstate_t st;
      logic req;
      logic we;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [1:0] pme_s;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } psm_host_t;

   psm_host_t s_r;
   psm_host_t s_nxt;
   logic acc;

   // Next-state logic: APB slave plus link master
   always_comb begin
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.pme_s = {s_r.pme_s[0], bus.pme};
      // One wait state: answer on the second access cycle
      acc = psel && penable && !s_r.pready;
      if (acc) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = 32'h00000000;
         unique case (paddr)
            PSM_H_CMD: begin
               if (pwrite && pwdata[PSM_HB_GO] && s_r.st == PSM_H_IDLE) begin
                  // host sends only legal orders
                  // Ordering is left to software; the controller just relays
                  s_nxt.st = PSM_H_BUSY;
                  s_nxt.req = 1'b1;
                  s_nxt.we = pwdata[PSM_HB_WR];
                  s_nxt.addr = pwdata[PSM_HB_ADDR +: 8];
               end
               s_nxt.prdata[PSM_HB_WR] = s_r.we;
               s_nxt.prdata[PSM_HB_ADDR +: 8] = s_r.addr;
            end
            PSM_H_WDATA: begin
               if (pwrite) s_nxt.wdata = pwdata;
               s_nxt.prdata = s_r.wdata;
            end
            PSM_H_RDATA: s_nxt.prdata = s_r.rdata;
            PSM_H_STAT: begin
               s_nxt.prdata[PSM_HB_BUSY] = s_r.st == PSM_H_BUSY;
               s_nxt.prdata[PSM_HB_PME] = s_r.pme_s[1];
            end
            default: s_nxt.pslverr = 1'b1;
         endcase
      end
      // Link transfer completes on ack
      if (s_r.st == PSM_H_BUSY && bus.ack) begin
         s_nxt.st = PSM_H_IDLE;
         s_nxt.req = 1'b0;
         if (!s_r.we) s_nxt.rdata = bus.rdata;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.st <= PSM_H_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign bus.req = s_r.req;
   assign bus.we = s_r.we;
   assign bus.addr = s_r.addr;
   assign bus.wdata = s_r.wdata;
endmodule

// ===== tb/psm_asserts.sv
// Handshake and read-data checks on the link wires between host controller and device.
// Expects the link signals plus the shared clock and reset as inputs.
`timescale 1ns/1ps
module psm_asserts
   import psm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   input wire logic ack,
   input wire logic pme
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_ack_next;
      req && !ack |=> ack;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not answered one cycle later");
   property p_ack_pulse;
      ack |=> !ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("answer longer than one cycle");
   property p_req_drop;
      ack |=> !req;
   endproperty
   a_req_drop: assert property (p_req_drop)
      else $error("request kept after answer");
   property p_req_hold;
      req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("request changed before answer");
   property p_ack_cause;
      ack |-> $past(req);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("answer without request");
   property p_rd_keep;
      ack && we |-> $stable(rdata);
   endproperty
   a_rd_keep: assert property (p_rd_keep)
      else $error("read data moved on a write");
   property p_test_val;
      ack && !we && addr == PSM_A_TEST |-> rdata == PSM_TEST_VAL || rdata == 32'h0;
   endproperty
   a_test_val: assert property (p_test_val)
      else $error("test register read wrong");
   property p_mode_rsv;
      ack && !we && addr == PSM_A_CTRL |-> rdata[PSM_B_MODE +: 2] != 2'h3;
   endproperty
   a_mode_rsv: assert property (p_mode_rsv)
      else $error("reserved state select read back");
   property p_rdy_mode;
      ack && !we && addr == PSM_A_CTRL && rdata[PSM_B_READY] |->
         rdata[PSM_B_MODE +: 2] == PSM_MODE_FULL;
   endproperty
   a_rdy_mode: assert property (p_rdy_mode)
      else $error("ready set outside normal state");
endmodule

// ===== tb/testbench.sv
// Bench for host controller and device joined by the link interface.
// Drives APB and the wake pins; timer counts shortened by parameter.
`timescale 1ns/1ps
module testbench;
   import psm_pkg::*;
   localparam logic [31:0] c_mode = 32'h3 << PSM_B_MODE;
   localparam logic [31:0] c_pme = 32'h1 << PSM_B_PME_EN;
   localparam logic [31:0] c_wol = c_pme | (32'h1 << PSM_B_PULSE) | (32'h1 << PSM_B_WAKE_LAN_ENABLE)
      | ({30'h0, PSM_MODE_WOL} << PSM_B_MODE);
   localparam logic [31:0] c_ed = c_pme | (32'h1 << PSM_B_ENERGY_WAKE_ENABLE)
      | ({30'h0, PSM_MODE_ED} << PSM_B_MODE);
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, wake_frame = 1'b0, carrier = 1'b0;
   logic ready, irq_status, mac_clk_en, int_clk_en, rx_pm_en, mac_pm_en;
   logic phy_pwr_down, phy_ed_mode, phy_reset;
   int n_errors = 0, n_checks = 0, n_rst = 0, n;
   psm_if lnk ();
   // 25 MHz clock
   always #20 pclk = ~pclk;
   // Counts PHY reset pulses
   always @(posedge pclk) if (phy_reset === 1'b1) n_rst <= n_rst + 1;
   psm_host psm_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(lnk));
   // Short timers keep the run brief
   psm_device #(.WAKE_CYC(20), .PULSE_CYC(40)) psm_device_inst (.pclk(pclk),
      .presetn(presetn), .bus(lnk), .wake_frame(wake_frame), .magic_pkt(1'b0),
      .carrier(carrier), .ready(ready), .irq_status(irq_status), .mac_clk_en(mac_clk_en),
      .int_clk_en(int_clk_en), .rx_pm_en(rx_pm_en), .mac_pm_en(mac_pm_en),
      .phy_pwr_down(phy_pwr_down), .phy_ed_mode(phy_ed_mode), .phy_reset(phy_reset));
   psm_asserts psm_asserts_inst (.pclk(pclk), .presetn(presetn), .req(lnk.req),
      .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack),
      .pme(lnk.pme));
   task close_out;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task fail;
      n_errors++;
      $display("BAD %0t wait ran out", $time);
      close_out;
   endtask
   // Waits for a falling edge, then compares the values captured when the task was called
   task chk(input logic [31:0] g, input logic [31:0] x);
      @(negedge pclk);
      n_checks++;
      if (g !== x) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, g, x);
      end
   endtask
   // One APB transfer; result lands in q and e
   // Answer is sampled at the rising edge, before that edge's updates land
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) fail;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One link transfer through the host registers
   task lk(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      apb(1'b1, PSM_H_WDATA, d);
      apb(1'b1, PSM_H_CMD, {16'h0000, a, 6'h00, w, 1'b1});
      for (k = 0; k < 20; k++) begin
         apb(1'b0, PSM_H_STAT, 32'h0);
         if (q[PSM_HB_BUSY] === 1'b0) break;
      end
      if (k == 20) fail;
      if (!w) apb(1'b0, PSM_H_RDATA, 32'h0);
   endtask
   // Waits for ready (s=0) or the event pin (s=1)
   task wfor(input logic s);
      int k;
      for (k = 0; k < 30; k++) begin
         @(negedge pclk);
         if ((s ? lnk.pme : ready) === 1'b1) break;
      end
      if (k == 30) fail;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      chk({ready, mac_clk_en, int_clk_en, rx_pm_en, mac_pm_en, irq_status, lnk.pme}, 7'h7C);
      lk(1'b1, PSM_A_CTRL, c_pme);
      lk(1'b0, PSM_A_CTRL, 32'h0);
      chk(q, 32'h1);
      lk(1'b0, PSM_A_TEST, 32'h0);
      chk(q, PSM_TEST_VAL);
      apb(1'b0, 8'h40, 32'h0);
      chk(e, 1'b1);
      lk(1'b1, PSM_A_PHY0, 32'h1 << PSM_B_PHY_PD);
      chk(phy_pwr_down, 1'b1);
      lk(1'b1, PSM_A_PHY0, 32'h0);
      chk({phy_pwr_down, n_rst[1:0]}, 3'h1);
      lk(1'b1, PSM_A_CTRL, c_mode);
      lk(1'b0, PSM_A_CTRL, 32'h0);
      chk(q, 32'h1);
      // Wake-on-LAN sleep with a pulsed event pin
      lk(1'b1, PSM_A_CTRL, c_wol);
      chk({ready, mac_clk_en, int_clk_en, rx_pm_en, mac_pm_en}, 5'h06);
      lk(1'b1, PSM_A_CTRL, 32'h0);
      lk(1'b0, PSM_A_TEST, 32'h0);
      chk(q, 32'h0);
      @(posedge pclk);
      wake_frame <= 1'b1;
      wfor(1'b1);
      for (n = 0; n < 200 && lnk.pme === 1'b1; n++) @(negedge pclk);
      chk(n >= 39 && n <= 41, 1'b1);
      chk(irq_status, 1'b1);
      lk(1'b0, PSM_A_CTRL, 32'h0);
      chk(q[PSM_B_WAKE_STATUS_FIELD +: 2], PSM_WAKE_STATUS_FIELD_WOL);
      @(posedge pclk);
      wake_frame <= 1'b0;
      lk(1'b1, PSM_A_TEST, 32'h0);
      wfor(1'b0);
      chk({mac_clk_en, mac_pm_en}, 2'h3);
      lk(1'b0, PSM_A_CTRL, 32'h0);
      chk(q, (c_wol & ~c_mode) | ({30'h0, PSM_WAKE_STATUS_FIELD_WOL} << PSM_B_WAKE_STATUS_FIELD) | 32'h1);
      lk(1'b1, PSM_A_CTRL, (c_wol & ~c_mode) | (32'h3 << PSM_B_WAKE_STATUS_FIELD));
      chk(irq_status, 1'b1);
      lk(1'b1, PSM_A_IRQ, 32'h1);
      chk(irq_status, 1'b0);
      // Energy sleep, carrier already present, static pin
      @(posedge pclk);
      carrier <= 1'b1;
      lk(1'b1, PSM_A_PHY17, 32'h1 << PSM_B_PHY_ED);
      chk(phy_ed_mode, 1'b1);
      lk(1'b1, PSM_A_CTRL, c_ed);
      chk({ready, mac_clk_en, int_clk_en, rx_pm_en, mac_pm_en}, 5'h00);
      wfor(1'b1);
      repeat (60) @(negedge pclk);
      chk(lnk.pme, 1'b1);
      apb(1'b0, PSM_H_STAT, 32'h0);
      chk(q[PSM_HB_PME], 1'b1);
      lk(1'b0, PSM_A_CTRL, 32'h0);
      chk(q[PSM_B_WAKE_STATUS_FIELD +: 2], PSM_WAKE_STATUS_FIELD_ED);
      @(posedge pclk);
      carrier <= 1'b0;
      lk(1'b1, PSM_A_TEST, 32'h5A5A5A5A);
      wfor(1'b0);
      lk(1'b0, PSM_A_CTRL, 32'h0);
      lk(1'b1, PSM_A_PHY17, 32'h0);
      chk(phy_ed_mode, 1'b0);
      lk(1'b1, PSM_A_CTRL, c_ed & ~c_mode & ~c_pme);
      chk(lnk.pme, 1'b0);
      lk(1'b1, PSM_A_IRQ, 32'h1);
      chk(irq_status, 1'b1);
      close_out;
   end
endmodule
